// *** inc/pod_pkg.sv ***
package pod_pkg;
	localparam int EXT_W = 40;
	localparam int INT_W = 32;
	localparam int EXP_LSB = 32;
	localparam int EXP_W = 8;
	localparam int MAN_W = 32;
	localparam int REG_N = 8;
	localparam int ADDR_W = 24;
	localparam logic [EXT_W-1:0] REG_RESET = 40'h00_0000_0000;
	localparam logic [7:0] EXP_ZERO = 8'h80;

	typedef enum logic [4:0] {
		POD_NOP = 5'h00,
		POD_MPYF_ADDF = 5'h01,
		POD_MPYF_SUBF = 5'h02,
		POD_MPYI_ADDI = 5'h03,
		POD_MPYI_SUBI = 5'h04,
		POD_ADDF_STF = 5'h05,
		POD_SUBF_STF = 5'h06,
		POD_MPYF_STF = 5'h07,
		POD_NEGATE_FLOAT_STF = 5'h08,
		POD_ADDI_STI = 5'h09,
		POD_SUBI_STI = 5'h0a,
		POD_MPYI_STI = 5'h0b,
		POD_NEGATE_INTEGER_STI = 5'h0c,
		POD_NOT_STI = 5'h0d,
		POD_OR_STI = 5'h0e,
		POD_XOR_STI = 5'h0f,
		POD_AND_STI = 5'h10,
		POD_STF_STF = 5'h11,
		POD_STI_STI = 5'h12,
		POD_LDF_LDF = 5'h13,
		POD_LDI_LDI = 5'h14
	} pod_op_e;

	typedef enum logic [1:0] {
		POD_IDLE = 2'b00,
		POD_EXEC = 2'b01,
		POD_DONE = 2'b11
	} pod_state_e;

	// One decoded parallel instruction
	typedef struct packed {
		pod_op_e op;
		logic [2:0] regA;      // op1/src1 register
		logic [2:0] regB;      // op2 register
		logic [2:0] regC;      // op4 / src3 register
		logic [2:0] regD;      // op5 register
		logic [3:0] srcIsMem;  // op1,op2,op4,op5 memory flags
		logic [2:0] dst1;      // op3 or dst1
		logic [2:0] dst2;      // op6 or load dst2
	} pod_instr_s;

	// Two memory words from the data buses
	typedef struct packed {
		logic [EXT_W-1:0] mem1;
		logic [EXT_W-1:0] mem2;
	} pod_mem_s;

	// Register write-back and store request
	typedef struct packed {
		logic wrA;
		logic fullA;
		logic [2:0] selA;
		logic [EXT_W-1:0] valA;
		logic wrB;
		logic fullB;
		logic [2:0] selB;
		logic [EXT_W-1:0] valB;
		logic store;
		logic [EXT_W-1:0] storeVal;
	} pod_wb_s;
endpackage

// *** rtl/pod_fmath.sv ***
`timescale 1ns/1ps
// Simplified 40-bit float add and multiply; exponent in 39:32, mantissa
// 31:0 as signed two's complement with implied leading one.
module pod_fmath (
	input wire logic [39:0] a, // Operand a
	input wire logic [39:0] b, // Operand b
	input wire logic subtract, // Subtract b from a
	output logic [39:0] sum, // Sum or difference
	output logic [39:0] prod // Product
);
	logic signed [8:0] ea, eb, es;
	logic signed [33:0] ma, mb, mbs, msum, mq;
	logic signed [67:0] mp;
	logic [4:0] sh;

	// Renormalise by one place either way; wider drifts are not handled
	function automatic logic [39:0] fnorm(input logic signed [8:0] e,
		input logic signed [33:0] m);
		logic signed [33:0] mn;
		logic signed [8:0] en;
		mn = m;
		en = e;
		if (m[33] != m[32]) begin
			mn = m >>> 1;
			en = e + 9'sd1;
		end else if (m[32] == m[31]) begin
			mn = m <<< 1;
			en = e - 9'sd1;
		end
		return {en[7:0], mn[32], mn[30:0]};
	endfunction

	// Align smaller operand to larger exponent; implied bit made explicit
	always_comb begin
		ea = {a[39], a[39:32]};
		eb = {b[39], b[39:32]};
		ma = {a[31], a[31], ~a[31], a[30:0]};
		mb = {b[31], b[31], ~b[31], b[30:0]};
		mbs = subtract ? -mb : mb;
		sh = 5'h00;
		if (ea >= eb) begin
			sh = ((ea - eb) > 9'sd31) ? 5'h1f : 5'((ea - eb));
			msum = ma + (mbs >>> sh);
			es = ea;
		end else begin
			sh = ((eb - ea) > 9'sd31) ? 5'h1f : 5'((eb - ea));
			msum = (ma >>> sh) + mbs;
			es = eb;
		end
		// Overflow costs one bit of precision, never a wrap
		sum = fnorm(es, msum);
		mp = ma * mb;
		mq = mp[64:31];
		prod = fnorm(ea + eb, mq);
	end
endmodule // pod_fmath

// *** rtl/pod_parallel_datapath.sv ***
`timescale 1ns/1ps
module pod_parallel_datapath (
	input wire logic clk, // 250 MHz core clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic instrValid, // Instruction offered
	input wire pod_pkg::pod_instr_s instr, // Decoded parallel pair
	input wire pod_pkg::pod_mem_s memIn, // Indirect operands from buses
	output logic instrReady, // Datapath can take an instruction
	output logic illegal, // Pulse: operand classes refused
	output pod_pkg::pod_wb_s wb, // Register write-back and store
	output logic [pod_pkg::EXT_W-1:0] regView [pod_pkg::REG_N] // Reg file
);
	pod_pkg::pod_state_e state_ff, nxt_state;
	pod_pkg::pod_instr_s instr_ff, nxt_instr;
	pod_pkg::pod_mem_s mem_ff, nxt_mem;
	pod_pkg::pod_wb_s wb_ff, nxt_wb;
	logic illegal_ff, nxt_illegal;
	logic ready_ff, nxt_ready;
	logic [pod_pkg::EXT_W-1:0] reg_ff [pod_pkg::REG_N];
	logic [pod_pkg::EXT_W-1:0] nxt_reg [pod_pkg::REG_N];
	logic [pod_pkg::EXT_W-1:0] opA, opB, opC, opD;
	logic [pod_pkg::EXT_W-1:0] fSum, fProd, fSum2, fProd2;
	logic [pod_pkg::INT_W-1:0] iProd, iSum;
	logic isMulPair, legal;
	logic [2:0] memCount;
	logic [1:0] memUsed;

	// Operand fetch: registers via the register buses, memory via data buses
	always_comb begin
		opA = instr_ff.srcIsMem[0] ? mem_ff.mem1 : reg_ff[instr_ff.regA];
		memUsed = {1'b0, instr_ff.srcIsMem[0]};
		if (instr_ff.srcIsMem[1]) begin
			opB = memUsed == 2'd0 ? mem_ff.mem1 : mem_ff.mem2;
		end else begin
			opB = reg_ff[instr_ff.regB];
		end
		memUsed = memUsed + {1'b0, instr_ff.srcIsMem[1]};
		if (instr_ff.srcIsMem[2]) begin
			opC = memUsed == 2'd0 ? mem_ff.mem1 : mem_ff.mem2;
		end else begin
			opC = reg_ff[instr_ff.regC];
		end
		memUsed = memUsed + {1'b0, instr_ff.srcIsMem[2]};
		if (instr_ff.srcIsMem[3]) begin
			opD = memUsed == 2'd0 ? mem_ff.mem1 : mem_ff.mem2;
		end else begin
			opD = reg_ff[instr_ff.regD];
		end
	end

	// Multiplier and ALU work side by side on the same instruction
	pod_fmath uMulAlu (
		.a(opA),
		.b(opB),
		.subtract(instr_ff.op == pod_pkg::POD_SUBF_STF),
		.sum(fSum2),
		.prod(fProd)
	);
	pod_fmath uAlu (
		.a(opC),
		.b(opD),
		.subtract(instr_ff.op == pod_pkg::POD_MPYF_SUBF),
		.sum(fSum),
		.prod(fProd2)
	);

	// Integer product keeps the low 32 bits of a 32x32 multiply
	always_comb begin
		iProd = 32'(opA[31:0] * opB[31:0]);
		unique case (instr_ff.op)
			pod_pkg::POD_MPYI_SUBI: iSum = opC[31:0] - opD[31:0];
			default: iSum = opC[31:0] + opD[31:0];
		endcase
	end

	// Operand class checks made at decode, before anything is written
	always_comb begin
		isMulPair = instr.op inside {pod_pkg::POD_MPYF_ADDF,
			pod_pkg::POD_MPYF_SUBF, pod_pkg::POD_MPYI_ADDI,
			pod_pkg::POD_MPYI_SUBI};
		memCount = 3'(instr.srcIsMem[0]) + 3'(instr.srcIsMem[1]) +
			3'(instr.srcIsMem[2]) + 3'(instr.srcIsMem[3]);
		legal = 1'b1;
		if (isMulPair) begin
			if (instr.dst1 > 3'd1) begin
				legal = 1'b0;
			end
			if (instr.dst2 != 3'd2 && instr.dst2 != 3'd3) begin
				legal = 1'b0;
			end
			if (memCount != 3'd2) begin
				legal = 1'b0;
			end
		end
		if (instr.op == pod_pkg::POD_NOP) begin
			legal = 1'b0;
		end
	end

	// Control: take, execute, write back; three cycles per pair
	always_comb begin
		nxt_state = state_ff;
		nxt_instr = instr_ff;
		nxt_mem = mem_ff;
		nxt_illegal = 1'b0;
		nxt_ready = ready_ff;
		unique case (state_ff)
			pod_pkg::POD_IDLE: begin
				nxt_ready = 1'b1;
				if (instrValid && ready_ff) begin
					if (legal) begin
						nxt_instr = instr;
						nxt_mem = memIn;
						nxt_state = pod_pkg::POD_EXEC;
						nxt_ready = 1'b0;
					end else begin
						nxt_illegal = 1'b1;
					end
				end
			end
			pod_pkg::POD_EXEC: begin
				nxt_state = pod_pkg::POD_DONE;
			end
			pod_pkg::POD_DONE: begin
				nxt_state = pod_pkg::POD_IDLE;
				nxt_ready = 1'b1;
			end
			default: begin
				nxt_state = pod_pkg::POD_IDLE;
			end
		endcase
	end

	// Result selection; both halves land in the same write-back cycle
	always_comb begin
		nxt_wb = '0;
		if (state_ff == pod_pkg::POD_EXEC) begin
			nxt_wb.selA = instr_ff.dst1;
			nxt_wb.selB = instr_ff.dst2;
			nxt_wb.storeVal = reg_ff[instr_ff.regC];
			unique case (instr_ff.op)
				pod_pkg::POD_MPYF_ADDF, pod_pkg::POD_MPYF_SUBF: begin
					nxt_wb.wrA = 1'b1;
					nxt_wb.fullA = 1'b1;
					nxt_wb.valA = fProd;
					nxt_wb.wrB = 1'b1;
					nxt_wb.fullB = 1'b1;
					nxt_wb.valB = fSum;
				end
				pod_pkg::POD_MPYI_ADDI, pod_pkg::POD_MPYI_SUBI: begin
					nxt_wb.wrA = 1'b1;
					nxt_wb.valA = {8'h00, iProd};
					nxt_wb.wrB = 1'b1;
					nxt_wb.valB = {8'h00, iSum};
				end
				pod_pkg::POD_LDF_LDF, pod_pkg::POD_LDI_LDI: begin
					nxt_wb.wrA = 1'b1;
					nxt_wb.wrB = 1'b1;
					nxt_wb.fullA = instr_ff.op == pod_pkg::POD_LDF_LDF;
					nxt_wb.fullB = instr_ff.op == pod_pkg::POD_LDF_LDF;
					nxt_wb.valA = mem_ff.mem1;
					nxt_wb.valB = mem_ff.mem2;
				end
				pod_pkg::POD_STF_STF, pod_pkg::POD_STI_STI: begin
					// First half also a store: src1 register to memory
					nxt_wb.store = 1'b1;
					nxt_wb.valA = reg_ff[instr_ff.regA];
				end
				default: begin
					nxt_wb.wrA = 1'b1;
					nxt_wb.store = 1'b1;
					nxt_wb.fullA = instr_ff.op inside {pod_pkg::POD_ADDF_STF,
						pod_pkg::POD_SUBF_STF, pod_pkg::POD_MPYF_STF,
						pod_pkg::POD_NEGATE_FLOAT_STF};
					unique case (instr_ff.op)
						pod_pkg::POD_ADDF_STF: nxt_wb.valA = fSum2;
						pod_pkg::POD_SUBF_STF: nxt_wb.valA = fSum2;
						pod_pkg::POD_MPYF_STF: nxt_wb.valA = fProd;
						pod_pkg::POD_NEGATE_FLOAT_STF: nxt_wb.valA =
							{opB[39:32], -opB[31:0]};
						pod_pkg::POD_ADDI_STI: nxt_wb.valA =
							{8'h00, opA[31:0] + opB[31:0]};
						pod_pkg::POD_SUBI_STI: nxt_wb.valA =
							{8'h00, opA[31:0] - opB[31:0]};
						pod_pkg::POD_MPYI_STI: nxt_wb.valA = {8'h00, iProd};
						pod_pkg::POD_NEGATE_INTEGER_STI: nxt_wb.valA =
							{8'h00, 32'h0000_0000 - opB[31:0]};
						pod_pkg::POD_NOT_STI: nxt_wb.valA = {8'h00, ~opA[31:0]};
						pod_pkg::POD_OR_STI: nxt_wb.valA =
							{8'h00, opA[31:0] | opB[31:0]};
						pod_pkg::POD_XOR_STI: nxt_wb.valA =
							{8'h00, opA[31:0] ^ opB[31:0]};
						default: nxt_wb.valA = {8'h00, opA[31:0] & opB[31:0]};
					endcase
				end
			endcase
		end
	end

	// Register file update; integer writes keep the exponent byte
	always_comb begin
		for (int i = 0; i < pod_pkg::REG_N; i++) begin
			nxt_reg[i] = reg_ff[i];
			if (wb_ff.wrA && wb_ff.selA == 3'(i)) begin
				nxt_reg[i] = wb_ff.fullA ? wb_ff.valA :
					{reg_ff[i][39:32], wb_ff.valA[31:0]};
			end
			if (wb_ff.wrB && wb_ff.selB == 3'(i)) begin
				nxt_reg[i] = wb_ff.fullB ? wb_ff.valB :
					{reg_ff[i][39:32], wb_ff.valB[31:0]};
			end
		end
	end

	// State registers only
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= pod_pkg::POD_IDLE;
			instr_ff <= '0;
			mem_ff <= '0;
			wb_ff <= '0;
			illegal_ff <= 1'b0;
			ready_ff <= 1'b0;
			for (int i = 0; i < pod_pkg::REG_N; i++) begin
				reg_ff[i] <= pod_pkg::REG_RESET;
			end
		end else begin
			state_ff <= nxt_state;
			instr_ff <= nxt_instr;
			mem_ff <= nxt_mem;
			wb_ff <= nxt_wb;
			illegal_ff <= nxt_illegal;
			ready_ff <= nxt_ready;
			for (int i = 0; i < pod_pkg::REG_N; i++) begin
				reg_ff[i] <= nxt_reg[i];
			end
		end
	end

	assign instrReady = ready_ff;
	assign illegal = illegal_ff;
	assign wb = wb_ff;
	assign regView = reg_ff;
endmodule // pod_parallel_datapath

// *** bench/pod_asserts.sv ***
`timescale 1ns/1ps
module pod_asserts (
	input wire logic clk, // Core clock
	input wire logic rst, // Sync reset
	input wire logic instrValid, // Offer
	input wire pod_pkg::pod_instr_s instr, // Offered pair
	input wire pod_pkg::pod_mem_s memIn, // Bus operands
	input wire logic instrReady, // Ready
	input wire logic illegal, // Refusal pulse
	input wire pod_pkg::pod_wb_s wb, // Write-back
	input wire logic [pod_pkg::EXT_W-1:0] regView [pod_pkg::REG_N] // Regs
);
	logic isMul, isInt, isLd, isSt, legal, take;
	pod_pkg::pod_mem_s memD1, memD2;
	pod_pkg::pod_wb_s wbD;
	// Own operand-class decode, so a slip in the design's is seen
	always_comb begin
		isMul = instr.op inside
			{[pod_pkg::POD_MPYF_ADDF:pod_pkg::POD_MPYI_SUBI]};
		isInt = instr.op inside
			{pod_pkg::POD_MPYI_ADDI, pod_pkg::POD_MPYI_SUBI};
		isLd = instr.op inside {pod_pkg::POD_LDF_LDF, pod_pkg::POD_LDI_LDI};
		isSt = instr.op inside {[pod_pkg::POD_ADDF_STF:pod_pkg::POD_STI_STI]};
		legal = instr.op != pod_pkg::POD_NOP && (!isMul
			|| (instr.dst1 < 3'd2 && instr.dst2[2:1] == 2'b01
			&& $countones(instr.srcIsMem) == 2));
		take = instrValid && instrReady && legal;
	end
	// Delay lines tie a write-back to the operands that caused it
	always_ff @(posedge clk) begin
		memD1 <= memIn;
		memD2 <= memD1;
		wbD <= wb;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_take; take; endsequence
	sequence s_busy; !instrReady [*2] ##1 instrReady; endsequence
	sequence s_wb; ##2 (wb.wrA || wb.wrB || wb.store); endsequence
	a_take_busy: assert property (s_take |=> s_busy)
		else $error("ready not back three edges after a take");
	a_take_answer: assert property (s_take |-> s_wb)
		else $error("no write-back two edges after a take");
	a_prod_dest: assert property ((take && isMul) |-> ##2 (wb.wrA
		&& wb.selA == $past(instr.dst1, 2) && wb.selA < 3'd2))
		else $error("product destination wrong");
	a_sum_dest: assert property ((take && isMul) |-> ##2 (wb.wrB
		&& wb.selB == $past(instr.dst2, 2) && wb.selB[2:1] == 2'b01))
		else $error("sum destination wrong");
	a_int_low: assert property ((take && isInt) |-> ##2
		(!wb.fullA && !wb.fullB)) else $error("integer pair wrote 40 bits");
	a_float_full: assert property ((take && isMul && !isInt) |-> ##2
		(wb.fullA && wb.fullB)) else $error("float pair not full width");
	a_bad_refused: assert property ((instrValid && instrReady && !legal)
		|=> (illegal && !wb.wrA && !wb.wrB && !wb.store))
		else $error("bad operand classes not refused");
	a_load_pair: assert property ((take && isLd) |-> ##2 (wb.wrA
		&& wb.wrB && wb.valA[31:0] == memD2.mem1[31:0]
		&& wb.valB[31:0] == memD2.mem2[31:0])) else $error("load pair wrong");
	a_store_pair: assert property ((take && isSt) |-> ##2
		(wb.store && !wb.wrB)) else $error("store pair did not store");
	a_reg_update: assert property ((wbD.wrA && !(wbD.wrB
		&& wbD.selB == wbD.selA)) |-> (regView[wbD.selA][31:0]
		== wbD.valA[31:0] && (!wbD.fullA
		|| regView[wbD.selA][39:32] == wbD.valA[39:32])))
		else $error("register file not updated from write-back");
endmodule // pod_asserts

// *** bench/pod_parallel_datapath_bench.sv ***
`timescale 1ns/1ps
module pod_parallel_datapath_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic instrValid = 1'b0;
	pod_pkg::pod_instr_s instr = '0;
	pod_pkg::pod_mem_s memIn = '0;
	logic instrReady, illegal;
	pod_pkg::pod_wb_s wb;
	logic [pod_pkg::EXT_W-1:0] regView [pod_pkg::REG_N];
	logic [39:0] mdl [8] = '{default: '0}; // Reference register file
	int err_total = 0;
	int checks = 0;
	bit known = 1'b1; // Arithmetic-store results are not modelled
	// Core clock, 4 ns period
	always #2 clk = ~clk;
	pod_parallel_datapath dut (.clk(clk), .rst(rst), .instrValid(instrValid),
		.instr(instr), .memIn(memIn), .instrReady(instrReady),
		.illegal(illegal), .wb(wb), .regView(regView));
	task automatic chk(input string what, input logic [39:0] exp,
		input logic [39:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Model the pair, offer it, hold until taken, then compare
	task automatic issue(input pod_pkg::pod_instr_s i,
		input pod_pkg::pod_mem_s m, input bit bad);
		logic [39:0] v [4];
		logic [39:0] p, s;
		logic [2:0] sel [4];
		int nm;
		int n;
		sel = '{i.regA, i.regB, i.regC, i.regD};
		nm = 0;
		n = 0;
		p = mdl[i.dst1];
		s = mdl[i.dst2];
		for (int k = 0; k < 4; k++) begin
			v[k] = mdl[sel[k]];
			if (i.srcIsMem[3-k]) begin
				v[k] = nm == 0 ? m.mem1 : m.mem2;
				nm++;
			end
		end
		case (i.op)
			pod_pkg::POD_MPYF_ADDF, pod_pkg::POD_MPYF_SUBF: begin
				p = {v[0][39:32] + v[1][39:32], 32'h0};
				s = i.op == pod_pkg::POD_MPYF_ADDF ? {v[2][39:32] + 8'h01, 32'h0}
					: {v[3][39:32], 32'h0};
			end
			pod_pkg::POD_MPYI_ADDI, pod_pkg::POD_MPYI_SUBI: begin
				p[31:0] = v[0][31:0] * v[1][31:0];
				s[31:0] = i.op == pod_pkg::POD_MPYI_ADDI ? v[2][31:0] + v[3][31:0]
					: v[2][31:0] - v[3][31:0];
			end
			pod_pkg::POD_LDF_LDF: begin
				p = m.mem1;
				s = m.mem2;
			end
			pod_pkg::POD_LDI_LDI: begin
				p[31:0] = m.mem1[31:0];
				s[31:0] = m.mem2[31:0];
			end
			default: ;
		endcase
		@(posedge clk);
		instrValid <= 1'b1;
		instr <= i;
		memIn <= m;
		do begin
			@(posedge clk);
			n++;
		end while (instrReady !== 1'b1 && n < 20);
		instrValid <= 1'b0;
		#1;
		if (bad) begin
			chk("illegal", 40'h1, {39'h0, illegal});
		end else begin
			@(posedge clk);
			#1;
			if (i.op inside {[pod_pkg::POD_ADDF_STF:pod_pkg::POD_STI_STI]}) begin
				chk("store", 40'h1, {39'h0, wb.store});
				chk("stored value", mdl[i.regC], wb.storeVal);
				if (i.op >= pod_pkg::POD_STF_STF)
					chk("store src1", mdl[i.regA], wb.valA);
				known = known && i.op >= pod_pkg::POD_STF_STF;
			end else begin
				chk("pair writes", 40'h3, {38'h0, wb.wrA, wb.wrB});
				mdl[i.dst1] = p;
				mdl[i.dst2] = s; // Second write wins on a clash
			end
		end
		@(posedge clk);
		#1;
		for (int k = 0; k < 8; k++) begin
			if (known) chk("register", mdl[k], regView[k]);
		end
	endtask
	// Main sequence
	initial begin
		pod_pkg::pod_instr_s i;
		pod_pkg::pod_mem_s m;
		logic [7:0] e;
		i = '0;
		m = '0;
		void'($urandom(32'hda13_7898));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// Fill the file; last two loads are integer-wide
		for (int k = 0; k < 6; k++) begin
			i.op = k < 4 ? pod_pkg::POD_LDF_LDF : pod_pkg::POD_LDI_LDI;
			i.dst1 = 3'(k < 4 ? 2 * k : $urandom);
			i.dst2 = 3'(k < 4 ? 2 * k + 1 : $urandom);
			m.mem1 = {8'($urandom), $urandom()};
			m.mem2 = {8'($urandom), $urandom()};
			issue(i, m, 1'b0);
		end
		// Integer pairs; splits are mirror-symmetric in flag order
		for (int k = 0; k < 8; k++) begin
			i.op = k % 2 ? pod_pkg::POD_MPYI_SUBI : pod_pkg::POD_MPYI_ADDI;
			i.srcIsMem = k > 3 ? 4'b1001 : 4'b0110;
			{i.regA, i.regB, i.regC, i.regD} = 12'($urandom);
			i.dst1 = 3'($urandom_range(1, 0));
			i.dst2 = 3'(2 + $urandom_range(1, 0));
			m.mem1 = {8'($urandom), $urandom()};
			m.mem2 = {8'($urandom), $urandom()};
			issue(i, m, 1'b0);
		end
		// Float pairs on powers of two, where every result is exact
		for (int k = 0; k < 4; k++) begin
			i.op = pod_pkg::POD_LDF_LDF;
			i.dst1 = 3'd4;
			i.dst2 = 3'd5;
			m.mem1 = {8'($urandom_range(20, 1)), 32'h0};
			m.mem2 = {8'($urandom_range(20, 1)), 32'h0};
			issue(i, m, 1'b0);
			e = 8'($urandom_range(20, 1));
			i.op = k % 2 ? pod_pkg::POD_MPYF_SUBF : pod_pkg::POD_MPYF_ADDF;
			i.srcIsMem = 4'b0110;
			i.regA = 3'd4;
			i.regD = 3'd5;
			i.dst1 = 3'(k % 2);
			i.dst2 = 3'(2 + k / 2);
			m.mem1 = {e, 32'h0};
			m.mem2 = {mdl[5][39:32] + 8'(k % 2), 32'h0};
			issue(i, m, 1'b0);
		end
		// Refused: bad destinations, bad source split, empty op
		for (int k = 0; k < 5; k++) begin
			i.op = k == 4 ? pod_pkg::POD_NOP : pod_pkg::POD_MPYI_ADDI;
			i.dst1 = 3'(k == 0 ? 2 : 0);
			i.dst2 = 3'(k == 1 ? 1 : 3);
			i.srcIsMem = k == 2 ? 4'b0001 : k == 3 ? 4'b0111 : 4'b1001;
			issue(i, m, 1'b1);
		end
		// Store pairs: plain stores first, arithmetic forms after
		for (int k = 0; k < 14; k++) begin
			i.op = pod_pkg::pod_op_e'(5'(k < 2 ? 17 + k : 3 + k));
			{i.regA, i.regB, i.regC, i.regD} = 12'($urandom);
			// Unmodelled results go to R6/R7; stored values come from R0-R5
			i.regC = 3'($urandom_range(5, 0));
			if (k < 2) i.regA = 3'($urandom_range(5, 0));
			i.srcIsMem = 4'b0100;
			i.dst1 = 3'(6 + $urandom_range(1, 0));
			issue(i, m, 1'b0);
		end
		tally_and_finish();
	end
	// Watchdog: the sequence needs a few hundred cycles at most
	initial begin
		#8000;
		err_total++;
		tally_and_finish();
	end
endmodule // pod_parallel_datapath_bench
bind pod_parallel_datapath pod_asserts uAsserts (.clk(clk), .rst(rst),
	.instrValid(instrValid), .instr(instr), .memIn(memIn),
	.instrReady(instrReady), .illegal(illegal), .wb(wb), .regView(regView));
